// ### inc/wdt_pkg.sv
// Purpose: Constants for the watchdog / interval timer block
// Assumes: Classic Wishbone slave, 32-bit data, byte addressed
// Notes:   Every offset, field position and reset value lives here
//
// How it works
// - Two modes only: a reloading interval timer and a processor watchdog.
// - Normal mode counts low-power 32.768 kHz ticks divided by 1, 16 or 256.
// - Normal mode is a 16-bit timer with unsigned 16-bit reload and count.
// - On overflow in periodic normal mode the counter reloads from the reload register.
// - Control bit 5 set by software turns the block into a watchdog.
// - Watchdog mode counts down from the reload value until zero.
// - Divide-by-256 with reload 0xFFFF gives the 512 second maximum timeout.
// - At zero the watchdog requests a reset, or an interrupt if bit 1 set.
// - In watchdog mode any refresh write reloads the count and starts a new timeout period.
// - After watchdog entry, reload and control writes are ignored until POR.
// - Resets other than power-on leave count and configuration untouched.
// - Counting halts while debug holds the core, resumes after release.
// - Counts in power-down by default; control bit 0 stops it then.
// - In normal mode a refresh write clears the pending timer interrupt.
// - Power-on reset loads 0x0040 into both reload and count registers.
// - Count register is read-only current count; writes have no effect.
// - Control bit 7 starts the counter when set, stops it when clear outside watchdog mode.
// - Control bit 6 selects periodic when set, free-running when clear.
// - Control bits 3:2 pick divide 1, 16 or 256; code 11 is reserved.
// - Control bit 8 counts up when set and down when clear; watchdog mode always counts down.

`default_nettype none

package wdt_pkg;

  // ****************************************************
  // Register byte addresses
  // ****************************************************
  localparam logic [31:0] ADDR_RELOAD  = 32'hFFFF0360;
  localparam logic [31:0] ADDR_COUNT   = 32'hFFFF0364;
  localparam logic [31:0] ADDR_CONTROL = 32'hFFFF0368;
  localparam logic [31:0] ADDR_REFRESH = 32'hFFFF036C;
  localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0370;

  // ****************************************************
  // Control field positions
  // ****************************************************
  localparam int CTL_PD_OFF  = 0;
  localparam int CTL_WD_IRQ  = 1;
  localparam int CTL_PRE_LO  = 2;
  localparam int CTL_PRE_HI  = 3;
  localparam int CTL_WD_MODE = 5;
  localparam int CTL_PERIOD  = 6;
  localparam int CTL_ENABLE  = 7;
  localparam int CTL_UP      = 8;
  localparam int CTL_W       = 9;
  localparam logic [8:0] CTL_WMASK = 9'h1EF;

  // ****************************************************
  // Status field positions
  // ****************************************************
  localparam int STS_IRQ    = 0;
  localparam int STS_LOCKED = 1;
  localparam int STS_RUN    = 2;

  // ****************************************************
  // Prescaler codes and terminal counts
  // ****************************************************
  localparam logic [1:0] PRE_DIV1   = 2'h0;
  localparam logic [1:0] PRE_DIV16  = 2'h1;
  localparam logic [1:0] PRE_DIV256 = 2'h2;
  localparam logic [7:0] DIV16_LAST  = 8'h0F;
  localparam logic [7:0] DIV256_LAST = 8'hFF;

  // ****************************************************
  // Reset values and count limits
  // ****************************************************
  localparam logic [15:0] RELOAD_RST  = 16'h0040;
  localparam logic [15:0] COUNT_RST   = 16'h0040;
  localparam logic [8:0]  CONTROL_RST = 9'h000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN   = 16'h0000;

endpackage

`default_nettype wire

// ### hdl/tick_prescaler.sv
// Purpose: Divides the low-power oscillator tick by 1, 16 or 256
// Assumes: OSC_TICK is a one-cycle pulse synchronous to CLK
// Notes:   Reserved code 11 yields no ticks at all

`timescale 1ns/10ps
`default_nettype none

module tick_prescaler
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Tick in and divider code
  input  wire logic       OSC_TICK,
  input  wire logic [1:0] DIV_SEL,
  // Divided tick
  output var  logic       TICK_OUT
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed
  {
    logic [7:0] cnt;
    logic       tick;
  } pre_s;

  pre_s s_r;
  pre_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (OSC_TICK)
    begin
      case (DIV_SEL)
        wdt_pkg::PRE_DIV1:
        begin
          s_nxt.tick = 1'b1;
          s_nxt.cnt  = 8'h00;
        end
        wdt_pkg::PRE_DIV16:
        begin
          s_nxt.tick = (s_r.cnt[3:0] == wdt_pkg::DIV16_LAST[3:0]);
          s_nxt.cnt  = s_r.cnt + 8'h01;
        end
        wdt_pkg::PRE_DIV256:
        begin
          s_nxt.tick = (s_r.cnt == wdt_pkg::DIV256_LAST);
          s_nxt.cnt  = s_r.cnt + 8'h01;
        end
        default:
        begin
          s_nxt.tick = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign TICK_OUT = s_r.tick;

endmodule // tick_prescaler

`default_nettype wire

// ### hdl/watchdog_interval_timer.sv
// Purpose: 16-bit interval timer that doubles as a processor watchdog
// Assumes: RST is the power-on reset only; other resets never reach here
// Notes:   Registers sit on a classic Wishbone slave with one-cycle ack

`timescale 1ns/10ps
`default_nettype none

module watchdog_interval_timer
#(
  parameter int CNT_W = 16
)
(
  // Clock and power-on reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [31:0] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output var  logic [31:0] DAT_O,
  output var  logic        ACK_O,
  // System side
  input  wire logic        OSC_TICK,
  input  wire logic        DEBUG_HALT,
  input  wire logic        POWER_DOWN,
  // Outcomes
  output var  logic        TIMER_IRQ,
  output var  logic        WATCHDOG_RESET
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed
  {
    logic [CNT_W-1:0]       reload;
    logic [CNT_W-1:0]       count;
    logic [wdt_pkg::CTL_W-1:0] ctrl;
    logic                   irq;
    logic                   wd_reset;
    logic                   ack;
    logic [31:0]            rdata;
  } tmr_s;

  tmr_s s_r;
  tmr_s s_nxt;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [15:0] merge16
  (
    input logic [15:0] old_v,
    input logic [31:0] wdat,
    input logic [3:0]  sel
  );
    logic [15:0] res;
    res = old_v;
    if (sel[0])
      res[7:0] = wdat[7:0];
    if (sel[1])
      res[15:8] = wdat[15:8];
    return res;
  endfunction

  function automatic logic [31:0] read_mux
  (
    input logic [31:0] adr,
    input tmr_s        st,
    input logic        run_v
  );
    logic [31:0] res;
    res = 32'h00000000;
    if (adr == wdt_pkg::ADDR_RELOAD)
      res[CNT_W-1:0] = st.reload;
    else if (adr == wdt_pkg::ADDR_COUNT)
      res[CNT_W-1:0] = st.count;
    else if (adr == wdt_pkg::ADDR_CONTROL)
      res[wdt_pkg::CTL_W-1:0] = st.ctrl;
    else if (adr == wdt_pkg::ADDR_STATUS)
    begin
      res[wdt_pkg::STS_IRQ]    = st.irq;
      res[wdt_pkg::STS_LOCKED] = st.ctrl[wdt_pkg::CTL_WD_MODE];
      res[wdt_pkg::STS_RUN]    = run_v;
    end
    else
      res = 32'h00000000;
    return res;
  endfunction

  // ****************************************************
  // Mode decode
  // ****************************************************
  logic       wd_mode;
  logic       enabled;
  logic       halted;
  logic       run;
  logic       tick;
  logic       pre_tick_in;
  logic [1:0] pre_sel;

  // Watchdog mode is the lock: the mode bit itself cannot be cleared
  // while locked, so only power-on reset leaves watchdog mode.
  assign wd_mode = s_r.ctrl[wdt_pkg::CTL_WD_MODE];
  assign enabled = s_r.ctrl[wdt_pkg::CTL_ENABLE] | wd_mode;
  assign halted  = DEBUG_HALT
                 | (POWER_DOWN & s_r.ctrl[wdt_pkg::CTL_PD_OFF]);
  assign run     = enabled & ~halted;
  assign pre_sel = s_r.ctrl[wdt_pkg::CTL_PRE_HI:wdt_pkg::CTL_PRE_LO];

  // Gate the raw tick, not the divided one, so a halt freezes the
  // prescaler phase as well and no partial period is lost or gained.
  assign pre_tick_in = OSC_TICK & run;

  // ****************************************************
  // Prescaler
  // ****************************************************
  tick_prescaler u_pre
  (
    .CLK      (CLK),
    .RST      (RST),
    .OSC_TICK (pre_tick_in),
    .DIV_SEL  (pre_sel),
    .TICK_OUT (tick)
  );

  // ****************************************************
  // Bus decode
  // ****************************************************
  logic bus_req;
  logic bus_wr;
  logic wr_reload;
  logic wr_control;
  logic wr_refresh;

  assign bus_req    = CYC_I & STB_I;
  // Writes land on the edge at which the master sees ack
  assign bus_wr     = bus_req & WE_I & s_r.ack;
  assign wr_reload  = bus_wr & (ADR_I == wdt_pkg::ADDR_RELOAD);
  assign wr_control = bus_wr & (ADR_I == wdt_pkg::ADDR_CONTROL);
  assign wr_refresh = bus_wr & (ADR_I == wdt_pkg::ADDR_REFRESH);

  // ****************************************************
  // Next state
  // ****************************************************
  logic [CNT_W-1:0] cnt_step;
  logic             overflow;
  logic             expire;
  logic             up;

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.wd_reset = 1'b0;
    cnt_step       = s_r.count;
    overflow       = 1'b0;
    expire         = 1'b0;
    up             = s_r.ctrl[wdt_pkg::CTL_UP];

    // Bus answer: one cycle after the request, dropped right after
    s_nxt.ack   = bus_req & ~s_r.ack;
    s_nxt.rdata = read_mux(ADR_I, s_r, run);

    // Configuration writes, refused once the watchdog is armed
    if (wr_reload && !wd_mode)
      s_nxt.reload = merge16(s_r.reload, DAT_I, SEL_I);
    if (wr_control && !wd_mode && SEL_I[0])
      s_nxt.ctrl[7:0] = DAT_I[7:0] & wdt_pkg::CTL_WMASK[7:0];
    if (wr_control && !wd_mode && SEL_I[1])
      s_nxt.ctrl[8] = DAT_I[8] & wdt_pkg::CTL_WMASK[8];

    // Counting
    if (tick)
    begin
      if (wd_mode)
      begin
        // Down only, whatever the direction bit says
        if (s_r.count == wdt_pkg::COUNT_MIN)
          cnt_step = s_r.reload;
        else
        begin
          cnt_step = s_r.count - 16'h0001;
          expire   = (cnt_step == wdt_pkg::COUNT_MIN);
        end
      end
      else if (up)
      begin
        overflow = (s_r.count == wdt_pkg::COUNT_MAX);
        cnt_step = s_r.count + 16'h0001;
      end
      else
      begin
        overflow = (s_r.count == wdt_pkg::COUNT_MIN);
        cnt_step = s_r.count - 16'h0001;
      end

      if (overflow)
      begin
        if (s_r.ctrl[wdt_pkg::CTL_PERIOD])
          cnt_step = s_r.reload;
        else if (up)
          cnt_step = wdt_pkg::COUNT_MIN;
        else
          cnt_step = wdt_pkg::COUNT_MAX;
      end
      s_nxt.count = cnt_step;
    end

    // Refresh in watchdog mode restarts the timeout; it beats a tick
    if (wr_refresh && wd_mode)
      s_nxt.count = s_r.reload;

    // Refresh clears the flag, but an overflow in the same cycle wins
    if (wr_refresh)
      s_nxt.irq = 1'b0;

    if (overflow)
      s_nxt.irq = 1'b1;

    if (expire && !(wr_refresh && wd_mode))
    begin
      if (s_r.ctrl[wdt_pkg::CTL_WD_IRQ])
        s_nxt.irq = 1'b1;
      else
        s_nxt.wd_reset = 1'b1;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Only power-on reset lands here; the processor reset this block
  // requests is not fed back, so the count runs on through it.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s_r          <= '0;
      s_r.reload   <= wdt_pkg::RELOAD_RST;
      s_r.count    <= wdt_pkg::COUNT_RST;
      s_r.ctrl     <= wdt_pkg::CONTROL_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign DAT_O          = s_r.rdata;
  assign ACK_O          = s_r.ack;
  assign TIMER_IRQ      = s_r.irq;
  assign WATCHDOG_RESET = s_r.wd_reset;

endmodule // watchdog_interval_timer

`default_nettype wire

// ### verif/wdt_checker_sva.sv
// Purpose: Port-level properties of the watchdog interval timer
// Assumes: Only the top ports are visible; control state stays hidden
// Notes:   Outcomes are tied to oscillator ticks and to bus strobes
`timescale 1ns/10ps
`default_nettype none
module wdt_checker
#(
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Wishbone
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // System side and outcomes
  input wire logic        OSC_TICK,
  input wire logic        DEBUG_HALT,
  input wire logic        POWER_DOWN,
  input wire logic        TIMER_IRQ,
  input wire logic        WATCHDOG_RESET
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic mapped;
  logic clr_ack;
  assign mapped = ADR_I inside {wdt_pkg::ADDR_RELOAD, wdt_pkg::ADDR_COUNT,
    wdt_pkg::ADDR_CONTROL, wdt_pkg::ADDR_REFRESH, wdt_pkg::ADDR_STATUS};
  assign clr_ack = CYC_I && STB_I && WE_I && ACK_O
    && ADR_I == wdt_pkg::ADDR_REFRESH;
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_rd_done;
    (CYC_I && STB_I && !WE_I && !ACK_O) ##1 ACK_O;
  endsequence
  a_ack_follows: assert property (s_req |=> ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_spurious: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  a_read_narrow: assert property (s_rd_done |-> DAT_O[31:16] == '0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property ((!mapped && !WE_I) ##0 s_rd_done
    |-> DAT_O == 32'h00000000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(RST) |-> !ACK_O && !TIMER_IRQ
    && !WATCHDOG_RESET)
    else $error("outputs active after reset");
  a_wdr_single: assert property (WATCHDOG_RESET |=> !WATCHDOG_RESET)
    else $error("reset request longer than one cycle");
  a_wdr_cause: assert property (WATCHDOG_RESET |-> $past(OSC_TICK, 2))
    else $error("reset request without a tick");
  a_irq_cause: assert property ($rose(TIMER_IRQ) |-> $past(OSC_TICK, 2))
    else $error("interrupt rose without a tick");
  a_irq_held: assert property (TIMER_IRQ && !clr_ack |=> TIMER_IRQ)
    else $error("interrupt dropped without refresh");
  // A set competing with the clear comes from the tick one cycle back
  a_irq_clear: assert property (clr_ack && !$past(OSC_TICK, 1)
    |=> !TIMER_IRQ)
    else $error("refresh did not clear interrupt");
endmodule // wdt_checker
bind watchdog_interval_timer wdt_checker #(.CNT_W(CNT_W)) u_wdt_checker (
  .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .OSC_TICK(OSC_TICK), .DEBUG_HALT(DEBUG_HALT), .POWER_DOWN(POWER_DOWN),
  .TIMER_IRQ(TIMER_IRQ), .WATCHDOG_RESET(WATCHDOG_RESET));
`default_nettype wire

// ### verif/watchdog_interval_timer_bench.sv
// Purpose: Self-checking bench with an integer model of the timer
// Assumes: One-cycle ack; count moves two cycles after a tick
// Notes:   Prescaler phase is only trusted straight after a reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected at %0t ns: got %h want %h", $time, got, exp); \
    end \
  end
module watchdog_interval_timer_bench;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, wen = 0;
  logic        osc = 0, halt = 0, pd = 0, ack, irq, wdr;
  logic [31:0] adr = '0, dat = '0, dq, q;
  logic [3:0]  sel = '0;
  int          err_count, num_checks, n_wdp, r;
  int          m_rel, m_cnt, m_ctl, m_irq, m_pc, m_wdp;
  // Shortest timeout software may program: 30 ms of 32.768 kHz ticks
  localparam int WD_MIN = 984;
  watchdog_interval_timer #(.CNT_W(16)) u_watchdog_interval_timer (
    .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(wen),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dq), .ACK_O(ack),
    .OSC_TICK(osc), .DEBUG_HALT(halt), .POWER_DOWN(pd),
    .TIMER_IRQ(irq), .WATCHDOG_RESET(wdr));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (!rst && wdr === 1'b1) n_wdp++;
  initial
  begin
    #2_000_000;
    err_count++;
    end_of_test();
  end
  // ****************************************************
  // Model
  // ****************************************************
  function automatic void step();
    m_pc++;
    if (m_ctl[3:2] == 3 || (m_ctl[3:2] == 1 && m_pc % 16 != 0)) return;
    if (m_ctl[3:2] == 2 && m_pc % 256 != 0) return;
    if (m_ctl[5])
    begin
      if (m_cnt == 0) m_cnt = m_rel;
      else if (--m_cnt == 0) if (m_ctl[1]) m_irq = 1; else m_wdp++;
    end
    else if (m_ctl[8])
    begin
      if (m_cnt == 65535) begin m_irq = 1; m_cnt = m_ctl[6] ? m_rel : 0; end
      else m_cnt++;
    end
    else if (m_cnt == 0) begin m_irq = 1; m_cnt = m_ctl[6] ? m_rel : 65535; end
    else m_cnt--;
  endfunction
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic tick(int n);
    repeat (n)
    begin
      @(posedge clk) osc <= 1;
      @(posedge clk) osc <= 0;
      repeat (2) @(posedge clk);
      if ((m_ctl[7] || m_ctl[5]) && !halt && !(pd && m_ctl[0])) step();
    end
  endtask
  task automatic wb(bit we, logic [31:0] a, d);
    @(posedge clk);
    {cyc, stb, wen, adr, dat, sel} <= {2'b11, we, a, d, 4'hF};
    // Only the watchdog process ends a wait for ack
    do @(posedge clk); while (ack !== 1'b1);
    q = dq;
    {cyc, stb, wen} <= 3'b000;
    if (we && a == wdt_pkg::ADDR_RELOAD && !m_ctl[5]) m_rel = d[15:0];
    if (we && a == wdt_pkg::ADDR_CONTROL && !m_ctl[5]) m_ctl = d[8:0] & 'h1EF;
    if (we && a == wdt_pkg::ADDR_REFRESH)
    begin
      m_irq = 0;
      if (m_ctl[5]) m_cnt = m_rel;
    end
  endtask
  task automatic rd(logic [31:0] a, logic [15:0] e);
    wb(0, a, 0);
    `CHK(q, {16'h0000, e})
  endtask
  task automatic check(string name);
    wb(0, wdt_pkg::ADDR_COUNT, 0);
    `CHK(q[15:0], 16'(m_cnt))
    `CHK(irq, 1'(m_irq))
    `CHK(n_wdp, m_wdp)
    $display("test %s done", name);
  endtask
  task automatic do_reset();
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    {m_rel, m_cnt, m_ctl, m_irq, m_pc, m_wdp, n_wdp} = {32'h40, 32'h40, 160'h0};
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************************
  // Tests
  // ****************************************************
  initial
  begin
    void'($urandom(83));
    do_reset();
    rd(wdt_pkg::ADDR_RELOAD, 16'h0040);
    rd(wdt_pkg::ADDR_COUNT, 16'h0040);
    rd(wdt_pkg::ADDR_CONTROL, 16'h0000);
    wb(1, wdt_pkg::ADDR_COUNT, 32'h00001234);
    rd(wdt_pkg::ADDR_COUNT, 16'h0040);
    wb(1, 32'hFFFF0374, 32'hFFFFFFFF);
    rd(32'hFFFF0374, 16'h0000);
    rd(wdt_pkg::ADDR_STATUS, 16'h0000);
    check("reset");
    r = 2 + $urandom_range(7);
    wb(1, wdt_pkg::ADDR_RELOAD, r);
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h000000C0);
    rd(wdt_pkg::ADDR_RELOAD, 16'(r));
    tick(66);
    check("periodic");
    wb(1, wdt_pkg::ADDR_REFRESH, $urandom);
    check("refresh clear");
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000040);
    tick(3);
    check("disabled");
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h000001C0);
    tick(5);
    check("count up");
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000080);
    tick(m_cnt + 1);
    check("free running");
    halt <= 1;
    tick(3);
    halt <= 0;
    tick(1);
    check("debug halt");
    pd <= 1;
    tick(2);
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000081);
    tick(2);
    pd <= 0;
    check("power down");
    for (int c = 1; c < 4; c++)
    begin
      do_reset();
      wb(1, wdt_pkg::ADDR_CONTROL, 32'h80 | (c << 2));
      tick(c == 2 ? 257 : 33);
      check("prescale");
    end
    do_reset();
    wb(1, wdt_pkg::ADDR_RELOAD, WD_MIN);
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000020);
    wb(1, wdt_pkg::ADDR_REFRESH, $urandom);
    tick(2);
    wb(1, wdt_pkg::ADDR_REFRESH, $urandom);
    tick(WD_MIN + 2);
    check("watchdog reset");
    wb(1, wdt_pkg::ADDR_RELOAD, 32'h00001234);
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000000);
    rd(wdt_pkg::ADDR_RELOAD, 16'(WD_MIN));
    rd(wdt_pkg::ADDR_CONTROL, 16'(m_ctl));
    // Locked and running, flag clear
    rd(wdt_pkg::ADDR_STATUS, 16'h0006);
    do_reset();
    wb(1, wdt_pkg::ADDR_RELOAD, WD_MIN);
    wb(1, wdt_pkg::ADDR_CONTROL, 32'h00000022);
    wb(1, wdt_pkg::ADDR_REFRESH, $urandom);
    tick(WD_MIN);
    check("watchdog irq");
    wb(1, wdt_pkg::ADDR_REFRESH, $urandom);
    check("watchdog irq clear");
    end_of_test();
  end
endmodule // watchdog_interval_timer_bench
`default_nettype wire
